// [core/brc_pkg.sv]
// package for the step-down regulator configuration block: offsets, fields, reset values
package brc_pkg;
	// register offsets on the byte-wide configuration port
	localparam logic [7:0] CFG_FIRST_ADDR  = 8'h35; // first configuration register
	localparam logic [7:0] CFG_SECOND_ADDR = 8'h36; // regulator_config_second
	localparam logic [7:0] PEAK_ADDR       = 8'h37; // peak_current_setting
	localparam logic [7:0] VOUT_ADDR       = 8'h38; // output_voltage_setting
	localparam logic [7:0] PIN_MASK_ADDR   = 8'h39; // control_pin_enable_mask

	// values after reset
	localparam logic [7:0] CFG_FIRST_RST   = 8'h00;
	localparam logic [7:0] CFG_SECOND_RST  = 8'h00;
	localparam logic [7:0] PEAK_RST        = 8'h00;
	localparam logic [7:0] VOUT_RST        = 8'h00;
	localparam logic [7:0] PIN_MASK_RST    = 8'h00;

	// writable bits; the rest read back as zero
	localparam logic [7:0] CFG_FIRST_MASK  = 8'hFF;
	localparam logic [7:0] CFG_SECOND_MASK = 8'h78;
	localparam logic [7:0] PEAK_MASK       = 8'h8F;
	localparam logic [7:0] VOUT_MASK       = 8'h3F;
	localparam logic [7:0] PIN_MASK_MASK   = 8'hFF;

	// field positions, first configuration register
	localparam int FREEWHEEL_SENSE_BIT = 0;
	localparam int FET_HALVING_BIT     = 1;
	localparam int FAST_MODE_BIT       = 5;
	// field positions, second configuration register
	localparam int ADAPTIVE_DIS_BIT    = 3;
	localparam int FORCED_PWM_BIT      = 4;
	localparam int PIN_FAST_EN_BIT     = 5;
	localparam int DROPOUT_DIS_BIT     = 6;
	// field positions, peak current register
	localparam int TABLE_BYPASS_BIT    = 7;
	localparam int PEAK_CODE_MSB       = 3;
	// field position, output voltage register
	localparam int VOUT_CODE_MSB       = 5;
	// control pin that may drive fast mode
	localparam int FAST_PIN_INDEX      = 4;

	// decode scales
	localparam logic [8:0]  PEAK_STEP_MA    = 9'h019;  // 25 mA per code
	localparam logic [12:0] VOUT_BASE_MV    = 13'h0226; // 550 mV at code zero
	localparam logic [5:0]  STEP_10_MV      = 6'h0A;
	localparam logic [5:0]  STEP_25_MV      = 6'h19;
	localparam logic [5:0]  STEP_50_MV      = 6'h32;

	// sequencing slot value that hands enable to the enable field
	localparam logic [2:0] SEQ_BY_ENABLE_FIELD = 3'h7;

	// step size selector supplied from outside
	typedef enum logic [1:0] {
		STEP_10 = 2'b00,
		STEP_25 = 2'b01,
		STEP_50 = 2'b10,
		STEP_RSV = 2'b11
	} brc_step_t;

	// enable field choices
	typedef enum logic [1:0] {
		EN_OFF  = 2'b00,
		EN_ON   = 2'b01,
		EN_PINS = 2'b10,
		EN_RSV  = 2'b11
	} brc_enable_t;
endpackage

// [core/brc_regulator_config.sv]
// configuration registers and enable logic of the third step-down regulator
// Function
// - bit one halves the power FET size
// - bit zero picks freewheel entry condition
// - bit six disables low dropout mode
// - bit five lets control pin four drive fast
// - bit three fixes peak current, else adaptive
// - bit seven picks table or code source
// - peak code applied only when table bypassed
// - peak code decodes in 25 mA steps
// - voltage is 0.55 V plus code times step
// - pin mask valid for slot 111, field 10
// - selected pin levels are ORed into enable
// - slot 111 hands enable after boot delay
`timescale 1ns/1ps
module brc_regulator_config (
	input  wire logic        i_clk,               // 10 MHz system clock
	input  wire logic        i_reset_n,           // asynchronous reset, active low
	input  wire logic        i_reg_wr,            // write strobe from the serial port engine
	input  wire logic        i_reg_rd,            // read strobe from the serial port engine
	input  wire logic [7:0]  i_reg_addr,          // register offset
	input  wire logic [7:0]  i_reg_wdata,         // write data
	output logic      [7:0]  o_reg_rdata,         // read data, held until next read
	input  wire logic [2:0]  i_sequencing_slot,   // sequencing field from the control register
	input  wire logic [1:0]  i_regulator_enable_select, // enable field
	input  wire logic        i_boot_delay_done,   // boot or power-on delay fully elapsed
	input  wire logic        i_sequencer_enable,  // enable from the sequencer for other slots
	input  wire logic [7:0]  i_multi_purpose_control_pin, // control pin levels
	input  wire logic [1:0]  i_voltage_step_size, // step selector from the range setting
	input  wire logic [8:0]  i_table_peak_ma,     // peak current from the internal table
	output logic             o_force_fet_halving,     // power FET halved
	output logic             o_freewheel_sense_select, // freewheel waits for switch node high
	output logic             o_dropout_mode_disable,  // low dropout mode forbidden
	output logic             o_fast_mode,             // fast, higher quiescent mode active
	output logic             o_forced_pulse_width_mode, // forced PWM
	output logic             o_adaptive_peak_mode,    // adaptive peak current in use
	output logic             o_peak_from_code,        // peak taken from the register code
	output logic      [8:0]  o_peak_current_ma,       // peak current setting in mA
	output logic      [12:0] o_output_voltage_mv,     // output voltage target in mV
	output logic             o_regulator_enable       // regulator enable
);

	logic [7:0]  cfg_first_q;   // first configuration register
	logic [7:0]  cfg_second_q;  // second configuration register
	logic [7:0]  peak_q;        // peak current register
	logic [7:0]  vout_q;        // output voltage register
	logic [7:0]  pin_mask_q;    // control pin enable mask
	logic [5:0]  step_mv;       // decoded step size
	logic [8:0]  peak_ma_d;     // next peak current
	logic [12:0] vout_mv_d;     // next output voltage
	logic        pin_or;        // OR of selected control pins
	logic        enable_d;      // next regulator enable
	logic        fast_d;        // next fast mode

	// register writes; undefined bits are never stored
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg_first_q  <= brc_pkg::CFG_FIRST_RST;
			cfg_second_q <= brc_pkg::CFG_SECOND_RST;
			peak_q       <= brc_pkg::PEAK_RST;
			vout_q       <= brc_pkg::VOUT_RST;
			pin_mask_q   <= brc_pkg::PIN_MASK_RST;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				brc_pkg::CFG_FIRST_ADDR: begin
					cfg_first_q <= i_reg_wdata & brc_pkg::CFG_FIRST_MASK;
				end
				brc_pkg::CFG_SECOND_ADDR: begin
					cfg_second_q <= i_reg_wdata & brc_pkg::CFG_SECOND_MASK;
				end
				brc_pkg::PEAK_ADDR: begin
					peak_q <= i_reg_wdata & brc_pkg::PEAK_MASK;
				end
				brc_pkg::VOUT_ADDR: begin
					vout_q <= i_reg_wdata & brc_pkg::VOUT_MASK;
				end
				brc_pkg::PIN_MASK_ADDR: begin
					pin_mask_q <= i_reg_wdata & brc_pkg::PIN_MASK_MASK;
				end
				default: begin
					// writes to other offsets are dropped
				end
			endcase
		end
	end

	// register reads; other offsets answer zero
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				brc_pkg::CFG_FIRST_ADDR:  o_reg_rdata <= cfg_first_q;
				brc_pkg::CFG_SECOND_ADDR: o_reg_rdata <= cfg_second_q;
				brc_pkg::PEAK_ADDR:       o_reg_rdata <= peak_q;
				brc_pkg::VOUT_ADDR:       o_reg_rdata <= vout_q;
				brc_pkg::PIN_MASK_ADDR:   o_reg_rdata <= pin_mask_q;
				default:                  o_reg_rdata <= 8'h00;
			endcase
		end
	end

	// step size decode; the reserved code falls back to the largest step
	always_comb begin
		case (brc_pkg::brc_step_t'(i_voltage_step_size))
			brc_pkg::STEP_10: step_mv = brc_pkg::STEP_10_MV;
			brc_pkg::STEP_25: step_mv = brc_pkg::STEP_25_MV;
			brc_pkg::STEP_50: step_mv = brc_pkg::STEP_50_MV;
			default:          step_mv = brc_pkg::STEP_50_MV;
		endcase
	end

	// linear voltage decode
	assign vout_mv_d = brc_pkg::VOUT_BASE_MV
		+ 13'(vout_q[brc_pkg::VOUT_CODE_MSB:0]) * 13'(step_mv);

	// peak current source: register code only when the table is bypassed
	always_comb begin
		if (peak_q[brc_pkg::TABLE_BYPASS_BIT]) begin
			peak_ma_d = 9'(peak_q[brc_pkg::PEAK_CODE_MSB:0]) * brc_pkg::PEAK_STEP_MA;
		end else begin
			peak_ma_d = i_table_peak_ma;
		end
	end

	// fast mode from its own bit, or from control pin four when allowed
	assign fast_d = cfg_first_q[brc_pkg::FAST_MODE_BIT]
		| (cfg_second_q[brc_pkg::PIN_FAST_EN_BIT]
		& i_multi_purpose_control_pin[brc_pkg::FAST_PIN_INDEX]);

	// OR of all selected control pins
	assign pin_or = |(pin_mask_q & i_multi_purpose_control_pin);

	// enable selection: the field rules only after the full boot delay
	always_comb begin
		if ((i_sequencing_slot == brc_pkg::SEQ_BY_ENABLE_FIELD) && i_boot_delay_done) begin
			case (brc_pkg::brc_enable_t'(i_regulator_enable_select))
				brc_pkg::EN_ON:   enable_d = 1'b1;
				brc_pkg::EN_PINS: enable_d = pin_or;
				default:          enable_d = 1'b0;
			endcase
		end else if (i_sequencing_slot == brc_pkg::SEQ_BY_ENABLE_FIELD) begin
			enable_d = 1'b0; // held off until the boot delay ends
		end else begin
			enable_d = i_sequencer_enable; // other slots belong to the sequencer
		end
	end

	// power stage controls, registered
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_force_fet_halving       <= 1'b0;
			o_freewheel_sense_select  <= 1'b0;
			o_dropout_mode_disable    <= 1'b0;
			o_forced_pulse_width_mode <= 1'b0;
			o_adaptive_peak_mode      <= 1'b1;
			o_peak_from_code          <= 1'b0;
			o_fast_mode               <= 1'b0;
		end else begin
			o_force_fet_halving       <= cfg_first_q[brc_pkg::FET_HALVING_BIT];
			o_freewheel_sense_select  <= cfg_first_q[brc_pkg::FREEWHEEL_SENSE_BIT];
			o_dropout_mode_disable    <= cfg_second_q[brc_pkg::DROPOUT_DIS_BIT];
			o_forced_pulse_width_mode <= cfg_second_q[brc_pkg::FORCED_PWM_BIT];
			o_adaptive_peak_mode      <= ~cfg_second_q[brc_pkg::ADAPTIVE_DIS_BIT];
			o_peak_from_code          <= peak_q[brc_pkg::TABLE_BYPASS_BIT];
			o_fast_mode               <= fast_d;
		end
	end

	// settings and enable, registered
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_peak_current_ma   <= 9'h000;
			o_output_voltage_mv <= brc_pkg::VOUT_BASE_MV;
			o_regulator_enable  <= 1'b0;
		end else begin
			o_peak_current_ma   <= peak_ma_d;
			o_output_voltage_mv <= vout_mv_d;
			o_regulator_enable  <= enable_d;
		end
	end

	// checks on the registered outputs
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	a_fet_halving: assert property (
		$past(cfg_first_q[1]) |-> o_force_fet_halving)
		else $error("fet halving not following its bit");
	a_freewheel_sel: assert property (
		o_freewheel_sense_select == $past(cfg_first_q[0]))
		else $error("freewheel select not following its bit");
	a_dropout_dis: assert property (
		$rose(cfg_second_q[6]) |=> o_dropout_mode_disable)
		else $error("dropout disable late");
	a_pin_fast: assert property (
		(!cfg_first_q[5] && !cfg_second_q[5]) |=> !o_fast_mode)
		else $error("fast mode without pin permission");
	a_adaptive_peak: assert property (
		cfg_second_q[3] |=> !o_adaptive_peak_mode)
		else $error("adaptive mode while peak fixed");
	a_peak_code: assert property (
		peak_q[7] |=> o_peak_current_ma == 9'($past(peak_q[3:0])) * 9'h019)
		else $error("peak current decode wrong");
	a_peak_table: assert property (
		!peak_q[7] |=> o_peak_current_ma == $past(i_table_peak_ma))
		else $error("table peak not used");
	a_vout_decode: assert property (
		(i_voltage_step_size == 2'b10 && vout_q[5:0] == 6'h3F) |=>
		o_output_voltage_mv == 13'h0E74)
		else $error("full scale voltage wrong");
	a_pin_enable: assert property (
		(i_sequencing_slot == 3'h7 && i_boot_delay_done && i_regulator_enable_select == 2'b10)
		|=> o_regulator_enable == $past(|(pin_mask_q & i_multi_purpose_control_pin)))
		else $error("pin enable OR wrong");
	a_boot_wait: assert property (
		(i_sequencing_slot == 3'h7 && !i_boot_delay_done) |=> !o_regulator_enable)
		else $error("enabled before boot delay");

	// forced pulse width mode is a plain registered copy
	a_fpwm_follow: assert property (
		o_forced_pulse_width_mode == $past(cfg_second_q[4]))
		else $error("forced pwm not following its bit");
	// dropout disable tracks its bit both ways
	a_dropout_follow: assert property (
		o_dropout_mode_disable == $past(cfg_second_q[6]))
		else $error("dropout disable not following its bit");
	// adaptive mode is the inverse of the fixed peak bit
	a_adaptive_follow: assert property (
		o_adaptive_peak_mode == !$past(cfg_second_q[3]))
		else $error("adaptive mode not following its bit");
	// peak source flag tracks the table bypass bit
	a_peak_source: assert property (
		o_peak_from_code == $past(peak_q[7]))
		else $error("peak source flag not following its bit");
	// permitted pin four raises fast mode
	a_fast_by_pin: assert property (
		(cfg_second_q[5] && i_multi_purpose_control_pin[4]) |=> o_fast_mode)
		else $error("pin four did not raise fast mode");
	// without permission pin four has no say in fast mode
	a_pin_ignored: assert property (
		!cfg_second_q[5] |=> o_fast_mode == $past(cfg_first_q[5]))
		else $error("fast mode moved by a forbidden pin");
	// top peak code decodes to 375 mA
	a_peak_full: assert property (
		(peak_q == 8'h8F) |=> o_peak_current_ma == 9'h177)
		else $error("full scale peak current wrong");
	// zero peak code decodes to zero current
	a_peak_zero: assert property (
		(peak_q == 8'h80) |=> o_peak_current_ma == 9'h000)
		else $error("zero peak current wrong");
	// zero voltage code gives the base voltage
	a_vout_base: assert property (
		(vout_q[5:0] == 6'h00) |=> o_output_voltage_mv == 13'h0226)
		else $error("base voltage wrong");
	// full scale with the 10 mV step
	a_vout_fine: assert property (
		(i_voltage_step_size == 2'b00 && vout_q[5:0] == 6'h3F) |=>
		o_output_voltage_mv == 13'h049C)
		else $error("full scale voltage wrong for the fine step");
	// full scale with the 25 mV step
	a_vout_mid: assert property (
		(i_voltage_step_size == 2'b01 && vout_q[5:0] == 6'h3F) |=>
		o_output_voltage_mv == 13'h084D)
		else $error("full scale voltage wrong for the middle step");
	// the spare step code falls back to 50 mV
	a_vout_spare: assert property (
		(i_voltage_step_size == 2'b11 && vout_q[5:0] == 6'h3F) |=>
		o_output_voltage_mv == 13'h0E74)
		else $error("full scale voltage wrong for the spare step code");
	// enable field choices other than pins while the slot is 111
	a_field_enable: assert property (
		(i_sequencing_slot == 3'h7 && i_regulator_enable_select != 2'b10) |=>
		o_regulator_enable == $past(i_boot_delay_done && i_regulator_enable_select == 2'b01))
		else $error("enable field not obeyed");
	// other slots pass the sequencer enable through
	a_seq_pass: assert property (
		(i_sequencing_slot != 3'h7) |=> o_regulator_enable == $past(i_sequencer_enable))
		else $error("sequencer enable not passed through");
	// bits without storage always hold zero
	a_spare_bits: assert property (
		cfg_second_q[7] == 1'b0 && cfg_second_q[2:0] == 3'h0
		&& peak_q[6:4] == 3'h0 && vout_q[7:6] == 2'h0)
		else $error("unstored bit held a one");
	// a voltage write lands one edge later, masked
	a_write_vout: assert property (
		(i_reg_wr && i_reg_addr == 8'h38) |=> vout_q == ($past(i_reg_wdata) & 8'h3F))
		else $error("voltage write lost");
	// a peak write lands one edge later, masked
	a_write_peak: assert property (
		(i_reg_wr && i_reg_addr == 8'h37) |=> peak_q == ($past(i_reg_wdata) & 8'h8F))
		else $error("peak write lost");
	// a mask read returns the value stored before the read edge
	a_read_mask: assert property (
		(i_reg_rd && i_reg_addr == 8'h39) |=> o_reg_rdata == $past(pin_mask_q))
		else $error("mask read wrong");
	// read data holds between reads
	a_read_hold: assert property (
		!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data moved without a read");
	// unmapped offsets read as zero
	a_read_unmapped: assert property (
		(i_reg_rd && (i_reg_addr < 8'h35 || i_reg_addr > 8'h39)) |=> o_reg_rdata == 8'h00)
		else $error("unmapped offset read not zero");
endmodule

// [dv/brc_pin_model.sv]
// control pin driver standing in for the external logic on the pins
`timescale 1ns/1ps
module brc_pin_model (
	input  wire logic       i_clk,  // system clock
	input  wire logic       i_next, // asks for a fresh pin pattern
	output logic      [7:0] o_pins  // control pin levels
);
	int seed = 87; // fixed seed so the pin patterns repeat run to run
	initial o_pins = 8'hA5;
	// pins only move just after an edge, so they stay synchronous to the clock
	always @(posedge i_clk) begin
		if (i_next) begin
			o_pins <= 8'($random(seed));
		end
	end
endmodule

// [dv/brc_regulator_config_tb.sv]
// self-checking bench for the regulator configuration block
`timescale 1ns/1ps
module brc_regulator_config_tb;
	logic        i_clk = 1'b0;     // 10 MHz clock
	logic        i_reset_n = 1'b0; // reset, active low
	logic        wr = 1'b0, rd = 1'b0, boot = 1'b0, seq_en = 1'b0, nxt = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, pins;
	logic [2:0]  slot = 3'h0;   // sequencing field
	logic [1:0]  fsel = 2'h0;   // enable field
	logic [1:0]  step = 2'h0;   // voltage step selector
	logic [8:0]  tbl = 9'h000;  // table peak current
	logic        fet, fw, ldo, fast, fpwm, adapt, pfc, en;
	logic [8:0]  peak;
	logic [12:0] vout;
	logic [7:0]  sh [8'h35:8'h39]; // shadow of the stored register bits
	int          err_total = 0, compares = 0, seed = 87;
	logic [15:0] corner [8] = '{16'h378F, 16'h383F, 16'h3780, 16'h3800,
		16'h3787, 16'h39FF, 16'h3A55, 16'h3620};

	always #50 i_clk = ~i_clk;

	brc_regulator_config i_brc_regulator_config (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .i_sequencing_slot(slot), .i_regulator_enable_select(fsel),
		.i_boot_delay_done(boot), .i_sequencer_enable(seq_en),
		.i_multi_purpose_control_pin(pins), .i_voltage_step_size(step),
		.i_table_peak_ma(tbl), .o_force_fet_halving(fet), .o_freewheel_sense_select(fw),
		.o_dropout_mode_disable(ldo), .o_fast_mode(fast), .o_forced_pulse_width_mode(fpwm),
		.o_adaptive_peak_mode(adapt), .o_peak_from_code(pfc), .o_peak_current_ma(peak),
		.o_output_voltage_mv(vout), .o_regulator_enable(en));

	brc_pin_model i_brc_pin_model (.i_clk(i_clk), .i_next(nxt), .o_pins(pins));

	// writable bits of each offset, zero for unmapped places
	function automatic logic [7:0] wmask(input logic [7:0] a);
		case (a)
			8'h35, 8'h39: return 8'hFF;
			8'h36: return 8'h78;
			8'h37: return 8'h8F;
			8'h38: return 8'h3F;
			default: return 8'h00;
		endcase
	endfunction

	// expected output voltage in mV; step code 11 reads as 50 mV
	function automatic logic [12:0] exp_vout(input logic [5:0] c, input logic [1:0] s);
		return 13'h226 + 13'(c) * (s == 2'h0 ? 13'h00A : s == 2'h1 ? 13'h019 : 13'h032);
	endfunction

	// compare one value and count it
	task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one byte write, strobe high for a single edge
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge i_clk);
		wr <= 1'b0;
		if (wmask(a) != 8'h00) sh[a] = d & wmask(a);
	endtask

	// one byte read, data checked just after the taking edge
	task automatic rd_chk(input logic [7:0] a);
		@(posedge i_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge i_clk);
		rd <= 1'b0;
		#1;
		chk(13'(rdata), 13'((wmask(a) != 8'h00) ? sh[a] : 8'h00));
	endtask

	// every derived output against the shadow and current inputs
	task automatic chk_all;
		chk(13'(fet), 13'(sh[8'h35][1]));
		chk(13'(fw), 13'(sh[8'h35][0]));
		chk(13'(ldo), 13'(sh[8'h36][6]));
		chk(13'(fast), 13'(sh[8'h35][5] | (sh[8'h36][5] & pins[4])));
		chk(13'(fpwm), 13'(sh[8'h36][4]));
		chk(13'(adapt), 13'(!sh[8'h36][3]));
		chk(13'(pfc), 13'(sh[8'h37][7]));
		chk(13'(peak), sh[8'h37][7] ? 13'(sh[8'h37][3:0]) * 13'h019 : 13'(tbl));
		chk(vout, exp_vout(sh[8'h38][5:0], step));
		chk(13'(en), 13'((slot == 3'h7) ? (boot & ((fsel == 2'h1) | ((fsel == 2'h2)
			& |(sh[8'h39] & pins)))) : seq_en));
	endtask

	// write, read back, fresh side inputs and pins, then check everything
	task automatic step_once(input logic [7:0] a, input logic [7:0] d);
		wr_reg(a, d);
		rd_chk(a);
		@(posedge i_clk);
		nxt <= 1'b1;
		slot <= ($random(seed) & 1) ? 3'h7 : 3'($random(seed));
		fsel <= 2'($random(seed));
		boot <= ($random(seed) % 4) != 0;
		seq_en <= 1'($random(seed));
		step <= 2'($random(seed));
		tbl <= 9'($random(seed));
		@(posedge i_clk);
		nxt <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		chk_all;
	endtask

	// verdict and end of run
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// cut a hang short
	initial begin
		repeat (8000) @(posedge i_clk);
		err_total++;
		summarize;
	end

	// main sequence: reset, reset values, corners, random traffic, second reset
	initial begin
		for (int a = 8'h35; a <= 8'h39; a++) sh[a] = 8'h00;
		repeat (11) @(posedge i_clk);
		#1;
		chk(vout, 13'h226);
		chk(13'(adapt), 13'h001);
		@(posedge i_clk);
		i_reset_n <= 1'b1;
		for (int a = 8'h34; a <= 8'h3A; a++) rd_chk(8'(a));
		for (int i = 0; i < 8; i++) step_once(corner[i][15:8], corner[i][7:0]);
		// full scale voltage under every step code, the spare one included
		wr_reg(8'h38, 8'h3F);
		for (int s = 0; s < 4; s++) begin
			@(posedge i_clk);
			step <= 2'(s);
			repeat (2) @(posedge i_clk);
			#1;
			chk(vout, exp_vout(6'h3F, 2'(s)));
		end
		repeat (60) step_once(8'h34 + 8'(($random(seed) & 32'hFF) % 7), 8'($random(seed)));
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		@(posedge i_clk);
		i_reset_n <= 1'b1;
		for (int a = 8'h35; a <= 8'h39; a++) sh[a] = 8'h00;
		repeat (2) @(posedge i_clk);
		#1;
		chk_all;
		rd_chk(8'h39);
		summarize;
	end
endmodule
